// ### logic/peak_host_params.svh
`ifndef PEAK_HOST_PARAMS_SVH
`define PEAK_HOST_PARAMS_SVH

// ****************************************************************
// Register map of the controller, byte addresses.
// ****************************************************************
`define CTRL_OFS        32'h0000_0000
`define ADDR_OFS        32'h0000_0004
`define WDATA_OFS       32'h0000_0008
`define STATUS_OFS      32'h0000_000c
`define RDATA_OFS       32'h0000_0010
`define DIV_OFS         32'h0000_0014

// ****************************************************************
// Control fields.
// ****************************************************************
`define CTRL_GO_BIT     0
`define CTRL_RD_BIT     1
`define CTRL_SETPTR_BIT 2
`define CTRL_TWO_BIT    3
`define CTRL_HS_BIT     4

// ****************************************************************
// Device side constants, and the controller's divider values.
// ****************************************************************
`define PEAK_PTR        8'h07
`define PEAK_RESET      16'h0000
`define PEAK_CLEAR      16'h0000
`define PEAK_DATA_MASK  16'h0ff0
`define HS_MASTER_CODE  8'h08
`define DEV_ADDR_RESET  7'h50
`define DIV_STD         16'h0271
`define DIV_HS          16'h0024

`endif

// ### logic/peak_host_pkg.sv
package peak_host_pkg;

    typedef enum logic [3:0] {
        ST_IDLE   = 4'b0000,
        ST_START  = 4'b0001,
        ST_BIT_LO = 4'b0010,
        ST_BIT_HI = 4'b0011,
        ST_ACK_LO = 4'b0100,
        ST_ACK_HI = 4'b0101,
        ST_RSTART = 4'b0110,
        ST_STOP_A = 4'b0111,
        ST_STOP_B = 4'b1000,
        ST_DONE   = 4'b1001
    } phase_type;

    typedef enum logic [2:0] {
        BY_HSCODE = 3'b000,
        BY_ADDR   = 3'b001,
        BY_PTR    = 3'b010,
        BY_UPPER  = 3'b011,
        BY_LOWER  = 3'b100
    } byte_kind_type;

endpackage : peak_host_pkg

// ### logic/peak_host.sv
`timescale 1ns/1ps
`include "peak_host_params.svh"

module peak_host
(
    input  wire logic                        clk_sys,
    input  wire logic                        reset,
    input  wire logic                        haddr_sel,
    input  wire logic [31:0]                 haddr,
    input  wire logic [1:0]                  htrans,
    input  wire logic                        hwrite,
    input  wire logic [2:0]                  hsize,
    input  wire logic [31:0]                 hwdata,
    input  wire logic                        hready,
    output logic      [31:0]                 hrdata,
    output logic                             hreadyout,
    output logic                             hresp,
    input  wire logic                        scl_in,
    output logic                             scl_out,
    output logic                             scl_oe,
    input  wire logic                        sda_in,
    output logic                             sda_out,
    output logic                             sda_oe
);
    import peak_host_pkg::*;

    // There is no arbitration: the engine assumes it is the only master on the bus.
    typedef struct packed {
        logic              aw_pend;
        logic [31:0]       a_addr;
        logic [31:0]       rdata;
        logic [6:0]        dev_addr;
        logic [15:0]       wdata;
        logic [15:0]       div_std;
        logic              rd;
        logic              setptr;
        logic              two;
        logic              hs;
        logic              busy;
        logic              nack_seen;
        logic [15:0]       result;
        phase_type         phase;
        byte_kind_type     kind;
        logic [7:0]        shreg;
        logic [2:0]        bitn;
        logic [15:0]       tick;
        logic              hs_now;
        logic              reading;
        logic              scl_low;
        logic              sda_low;
        logic [1:0]        sda_sync;
        logic [1:0]        scl_sync;
    } state_type;

    state_type s_r;
    state_type s_nxt;

    function automatic logic [7:0] addr_byte(input logic [6:0] a, input logic r);
        addr_byte = {a, r};
    endfunction : addr_byte

    // ****************************************************************
    // Next state.
    // ****************************************************************
    always_comb
    begin
        logic        sda_s;
        logic        tick_done;
        logic [15:0] div;
        sda_s     = s_r.sda_sync[1];
        // High speed uses a fixed divider; only the standard one is programmable.
        div       = s_r.hs_now ? `DIV_HS : s_r.div_std;
        tick_done = (s_r.tick == 16'h0000);
        s_nxt     = s_r;
        s_nxt.sda_sync = {s_r.sda_sync[0], sda_in};
        s_nxt.scl_sync = {s_r.scl_sync[0], scl_in};
        s_nxt.tick = tick_done ? div : s_r.tick - 16'h0001;

        // ****************************************************************
        // Bus slave.
        // ****************************************************************
        // Bus slave: writes land in the data phase, reads answer with zero wait.
        s_nxt.aw_pend = 1'b0;
        if (s_r.aw_pend)
        begin
            if (s_r.a_addr == `CTRL_OFS)
            begin
                if (hwdata[`CTRL_GO_BIT] && !s_r.busy)
                begin
                    s_nxt.rd        = hwdata[`CTRL_RD_BIT];
                    s_nxt.setptr    = hwdata[`CTRL_SETPTR_BIT];
                    s_nxt.two       = hwdata[`CTRL_TWO_BIT];
                    s_nxt.hs        = hwdata[`CTRL_HS_BIT];
                    s_nxt.busy      = 1'b1;
                    s_nxt.nack_seen = 1'b0;
                    s_nxt.phase     = ST_START;
                    s_nxt.hs_now    = 1'b0;
                    s_nxt.tick      = s_r.div_std;
                    s_nxt.kind      = hwdata[`CTRL_HS_BIT] ? BY_HSCODE : BY_ADDR;
                end
            end
            else if (s_r.a_addr == `ADDR_OFS)
                s_nxt.dev_addr = hwdata[6:0];
            else if (s_r.a_addr == `WDATA_OFS)
                s_nxt.wdata = hwdata[15:0] & `PEAK_DATA_MASK;
            else if (s_r.a_addr == `DIV_OFS)
                s_nxt.div_std = hwdata[15:0];
        end
        if (hready && htrans[1] && haddr_sel)
        begin
            s_nxt.aw_pend = hwrite;
            s_nxt.a_addr  = haddr;
            if (!hwrite)
            begin
                // Read data is registered in the address phase and stands through the data phase.
                if (haddr == `CTRL_OFS)
                    s_nxt.rdata = {27'h0, s_r.hs, s_r.two, s_r.setptr, s_r.rd, 1'b0};
                else if (haddr == `ADDR_OFS)
                    s_nxt.rdata = {25'h0, s_r.dev_addr};
                else if (haddr == `WDATA_OFS)
                    s_nxt.rdata = {16'h0, s_r.wdata};
                else if (haddr == `STATUS_OFS)
                    s_nxt.rdata = {30'h0, s_r.nack_seen, s_r.busy};
                else if (haddr == `RDATA_OFS)
                    s_nxt.rdata = {16'h0, s_r.result};
                else if (haddr == `DIV_OFS)
                    s_nxt.rdata = {16'h0, s_r.div_std};
                else
                    s_nxt.rdata = 32'h0000_0000;
            end
        end

        // ****************************************************************
        // Two-wire engine.
        // ****************************************************************
        // Two-wire engine; it moves one step on each tick of the bit-rate divider, and a phase can take several steps.
        if (tick_done)
        begin
            case (s_r.phase)
                ST_IDLE:
                begin
                    s_nxt.scl_low = 1'b0;
                    s_nxt.sda_low = 1'b0;
                end
                ST_START:
                begin
                    // Data falls while the clock is still high, which marks the start.
                    s_nxt.sda_low = 1'b1;
                    s_nxt.phase   = ST_BIT_LO;
                    s_nxt.bitn    = 3'h7;
                    s_nxt.reading = 1'b0;
                    if (s_r.kind == BY_HSCODE)
                        s_nxt.shreg = `HS_MASTER_CODE;
                    else
                        s_nxt.shreg = addr_byte(s_r.dev_addr, s_r.rd && !s_r.setptr);
                end
                ST_BIT_LO:
                begin
                    // Lower the clock first and move data only once it is low, so a data
                    // edge never meets a high clock and looks like a start or a stop.
                    if (!s_r.scl_low)
                        s_nxt.scl_low = 1'b1;
                    else
                    begin
                        s_nxt.sda_low = !s_r.reading && !s_r.shreg[7];
                        s_nxt.phase   = ST_BIT_HI;
                    end
                end
                ST_BIT_HI:
                begin
                    s_nxt.scl_low = 1'b0;
                    // Clock stretching: wait for the line to rise before sampling.
                    if (s_r.scl_sync[1])
                    begin
                        s_nxt.shreg = {s_r.shreg[6:0], sda_s};
                        s_nxt.bitn  = s_r.bitn - 3'h1;
                        s_nxt.phase = (s_r.bitn == 3'h0) ? ST_ACK_LO : ST_BIT_LO;
                    end
                end
                ST_ACK_LO:
                begin
                    if (!s_r.scl_low)
                        s_nxt.scl_low = 1'b1;
                    else
                    begin
                        // Master acks an upper byte only when the lower one is wanted.
                        s_nxt.sda_low = s_r.reading && s_r.kind == BY_UPPER && s_r.two;
                        s_nxt.phase   = ST_ACK_HI;
                        if (s_r.reading)
                            s_nxt.result = (s_r.kind == BY_UPPER) ? {s_r.shreg, 8'h00}
                                                                  : {s_r.result[15:8], s_r.shreg};
                    end
                end
                ST_ACK_HI:
                begin
                    s_nxt.scl_low = 1'b0;
                    if (s_r.scl_sync[1])
                    begin
                        s_nxt.bitn    = 3'h7;
                        s_nxt.reading = 1'b0;
                        s_nxt.phase   = ST_BIT_LO;
                        if (s_r.kind == BY_HSCODE)
                        begin
                            s_nxt.hs_now = 1'b1;
                            s_nxt.kind   = BY_ADDR;
                            s_nxt.phase  = ST_RSTART;
                        end
                        else if (!s_r.reading && sda_s)
                        begin
                            // A refused byte ends the transfer; software sees it in the status.
                            s_nxt.nack_seen = 1'b1;
                            s_nxt.phase     = ST_STOP_A;
                        end
                        else if (s_r.kind == BY_ADDR)
                        begin
                            if (s_r.rd && !s_r.setptr)
                            begin
                                s_nxt.kind    = BY_UPPER;
                                s_nxt.reading = 1'b1;
                            end
                            else
                            begin
                                s_nxt.kind  = BY_PTR;
                                s_nxt.shreg = `PEAK_PTR;
                            end
                        end
                        else if (s_r.kind == BY_PTR)
                        begin
                            if (s_r.rd)
                            begin
                                s_nxt.setptr = 1'b0;
                                s_nxt.kind   = BY_ADDR;
                                s_nxt.phase  = ST_RSTART;
                            end
                            else
                            begin
                                s_nxt.kind  = BY_UPPER;
                                s_nxt.shreg = s_r.wdata[15:8];
                            end
                        end
                        else if (s_r.kind == BY_UPPER && s_r.two)
                        begin
                            s_nxt.kind    = BY_LOWER;
                            s_nxt.reading = s_r.rd;
                            s_nxt.shreg   = s_r.wdata[7:0];
                        end
                        else
                            s_nxt.phase = ST_STOP_A;
                    end
                end
                ST_RSTART:
                begin
                    // Take the clock low first so the far side drops its acknowledge, then
                    // release data and clock together; data is already released here.
                    if (!s_r.scl_low)
                        s_nxt.scl_low = 1'b1;
                    else
                    begin
                        s_nxt.sda_low = 1'b0;
                        s_nxt.scl_low = 1'b0;
                        s_nxt.phase   = ST_START;
                    end
                end
                ST_STOP_A:
                begin
                    if (!s_r.scl_low)
                        s_nxt.scl_low = 1'b1;
                    else
                    begin
                        s_nxt.sda_low = 1'b1;
                        s_nxt.phase   = ST_STOP_B;
                    end
                end
                ST_STOP_B:
                begin
                    s_nxt.scl_low = 1'b0;
                    s_nxt.phase   = ST_DONE;
                end
                ST_DONE:
                begin
                    // Data rises while the clock is high: this is the stop.
                    s_nxt.sda_low = 1'b0;
                    s_nxt.hs_now  = 1'b0;
                    s_nxt.busy    = 1'b0;
                    s_nxt.phase   = ST_IDLE;
                end
                default:
                    s_nxt.phase = ST_IDLE;
            endcase
        end
    end

    // ****************************************************************
    // State register.
    // ****************************************************************
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            s_r          <= '0;
            s_r.dev_addr <= `DEV_ADDR_RESET;
            s_r.div_std  <= `DIV_STD;
            s_r.wdata    <= `PEAK_CLEAR;
            s_r.result   <= `PEAK_RESET;
            s_r.sda_sync <= 2'b11;
            s_r.scl_sync <= 2'b11;
            s_r.phase    <= ST_IDLE;
            s_r.kind     <= BY_ADDR;
        end
        else
            s_r <= s_nxt;
    end

    assign hrdata    = s_r.rdata;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign scl_out   = 1'b0;
    assign scl_oe    = s_r.scl_low;
    assign sda_out   = 1'b0;
    assign sda_oe    = s_r.sda_low;

endmodule : peak_host

// ### verif/peak_host_props.sv
`timescale 1ns/1ps
// ****************
// Bus and wire checks.
// ****************
module peak_host_props
(
    input wire logic        clk_sys,
    input wire logic        reset,
    input wire logic        haddr_sel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        scl_in,
    input wire logic        scl_oe,
    input wire logic        sda_out,
    input wire logic        sda_oe
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);
    sequence start_seen;
        $rose(sda_oe) && !scl_oe;
    endsequence
    sequence stop_seen;
        $fell(sda_oe) && !scl_oe;
    endsequence
    // Phases last DIV+1 clocks, so a DIV below 3 would trip the hold checks.
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    a_rdata_cause: assert property
        ($changed(hrdata) |-> $past(haddr_sel && htrans[1] && !hwrite && hready))
        else $error("read data changed without a read");
    a_pull_only: assert property (!sda_out)
        else $error("data line driven high");
    a_start_high: assert property (start_seen |-> scl_in)
        else $error("start with clock low");
    a_start_clock: assert property (start_seen |-> ##[1:700] scl_oe)
        else $error("no clock after start");
    a_stop_idle: assert property (stop_seen |=> (!scl_oe && !sda_oe) [*3])
        else $error("bus not idle after stop");
    a_data_steady: assert property ($fell(scl_oe) |=> $stable(sda_oe) [*3])
        else $error("data moved while clock high");
    a_clk_phase: assert property ($changed(scl_oe) |=> $stable(scl_oe) [*3])
        else $error("clock phase too short");
    a_idle_reset: assert property ($fell(reset) |-> !scl_oe && !sda_oe)
        else $error("bus driven after reset");
    a_data_after_low: assert property (($changed(sda_oe) && scl_oe) |-> $past(scl_oe))
        else $error("data moved in the cycle the clock fell");
endmodule : peak_host_props

bind peak_host peak_host_props u_props (.clk_sys(clk_sys), .reset(reset),
    .haddr_sel(haddr_sel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .scl_in(scl_in),
    .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe));

// ### verif/peak_device_model.sv
`timescale 1ns/1ps
`include "peak_host_params.svh"
// ****************
// Converter side of the two-wire bus.
// ****************
module peak_device_model #(parameter logic [6:0] DEV_ADDR = 7'h50)
(
    input  wire logic       scl,
    input  wire logic       sda,
    input  wire logic       auto_mode,
    input  wire logic       conv_stb,
    input  wire logic [7:0] conv_val,
    input  wire logic       slow,
    output logic            sda_pull,
    output logic            scl_pull,
    output logic [15:0]     peak
);
    logic [7:0] ptr = 8'h00;
    logic       rs;
    task automatic get_byte(output logic [7:0] v);
        repeat (8) @(posedge scl) v = {v[6:0], sda};
        @(negedge scl);
    endtask : get_byte
    // Holding the clock low tests that the controller waits for the wire.
    task automatic give_ack();
        sda_pull = 1;
        scl_pull = slow;
        if (slow) #600;
        scl_pull = 0;
        @(negedge scl);
        sda_pull = 0;
    endtask : give_ack
    task automatic put_byte(input logic [7:0] v, output logic m);
        for (int i = 7; i >= 0; i--)
        begin
            sda_pull = !v[i];
            @(negedge scl);
        end
        sda_pull = 0;
        @(posedge scl) m = sda;
        @(negedge scl);
    endtask : put_byte
    task automatic session();
        logic [7:0] b, hi, lo;
        logic       m;
        get_byte(b);
        if (b[7:1] != DEV_ADDR) wait (0);
        give_ack();
        if (b[0])
            forever
            begin
                put_byte(ptr == `PEAK_PTR ? peak[15:8] : 8'h00, m);
                if (m) wait (0);
                put_byte(ptr == `PEAK_PTR ? peak[7:0] : 8'h00, m);
                if (m) wait (0);
            end
        get_byte(ptr);
        give_ack();
        forever
        begin
            get_byte(hi);
            give_ack();
            get_byte(lo);
            give_ack();
            if (ptr == `PEAK_PTR) peak = {hi, lo} & `PEAK_DATA_MASK;
        end
    endtask : session
    always @(posedge conv_stb)
        if (auto_mode && conv_val > peak[11:4]) peak[11:4] = conv_val;
    initial
    begin
        sda_pull = 0;
        scl_pull = 0;
        peak = `PEAK_RESET;
        forever
        begin
            @(negedge sda iff scl);
            do
            begin
                rs = 0;
                fork : xfer
                    session();
                    @(posedge sda iff scl);
                    @(negedge sda iff scl) rs = 1;
                join_any
                disable xfer;
                sda_pull = 0;
                scl_pull = 0;
            end
            while (rs);
        end
    end
endmodule : peak_device_model

// ### verif/testbench.sv
`timescale 1ns/1ps
`include "peak_host_params.svh"
module testbench;
    logic        clk_sys = 0, reset = 1, haddr_sel = 0, hwrite = 0, dph = 0;
    logic        auto_mode = 0, conv_stb = 0, slow = 0;
    logic [31:0] haddr = 0, hwdata = 0, rdata, hrdata, exp_q[$], msk_q[$];
    logic [1:0]  htrans = 0;
    logic [2:0]  hsize = 0;
    logic [7:0]  conv_val = 0;
    logic [15:0] ep, wd, peak;
    logic        hreadyout, hresp, scl_oe, sda_oe, dev_scl, dev_sda;
    wire         scl = !(scl_oe || dev_scl);
    wire         sda = !(sda_oe || dev_sda);
    integer      seed = 24986;
    int          num_errors = 0, cmp_count = 0;
    peak_host DUT (.clk_sys(clk_sys), .reset(reset), .haddr_sel(haddr_sel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .scl_in(scl), .scl_out(),
        .scl_oe(scl_oe), .sda_in(sda), .sda_out(), .sda_oe(sda_oe));
    peak_device_model #(.DEV_ADDR(`DEV_ADDR_RESET)) dev (.scl(scl), .sda(sda),
        .auto_mode(auto_mode), .conv_stb(conv_stb), .conv_val(conv_val), .slow(slow),
        .sda_pull(dev_sda), .scl_pull(dev_scl), .peak(peak));
    initial forever #2 clk_sys = !clk_sys;
    task automatic finish_test();
        $display("TB: %0d errors in %0d comparisons", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : finish_test
    task automatic hang();
        num_errors++;
        finish_test();
    endtask : hang
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    always @(posedge clk_sys)
        if (dph && hreadyout) check(hrdata & msk_q.pop_front(), exp_q.pop_front());
    task automatic ready_edge();
        int n;
        n = 0;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) hang();
    endtask : ready_edge
    task automatic ahb(input logic w, input logic [31:0] a, d, input logic note);
        haddr_sel <= 1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        hsize <= 3'b010;
        ready_edge();
        haddr_sel <= 0;
        htrans <= 2'b00;
        hwdata <= d;
        dph <= note;
        ready_edge();
        dph <= 0;
        rdata = hrdata;
    endtask : ahb
    task automatic rd(input logic [31:0] a, e, m);
        msk_q.push_back(m);
        exp_q.push_back(e & m);
        ahb(0, a, 0, 1);
    endtask : rd
    // Flags are {hs, two, setptr, rd}; busy is polled since transfer time varies.
    task automatic run(input logic [3:0] f);
        int n;
        ahb(1, `CTRL_OFS, {27'h0, f, 1'b1}, 0);
        n = 0;
        do
        begin
            ahb(0, `STATUS_OFS, 0, 0);
            n++;
        end
        while (rdata[0] !== 1'b0 && n < 20000);
        if (n == 20000) hang();
    endtask : run
    task automatic convert(input int k, input logic a);
        logic [7:0] v;
        auto_mode <= a;
        repeat (k)
        begin
            v = $random(seed);
            conv_val <= v;
            conv_stb <= 1;
            if (a && v > ep[11:4]) ep[11:4] = v;
            @(posedge clk_sys);
            conv_stb <= 0;
            @(posedge clk_sys);
        end
    endtask : convert
    initial
    begin
        repeat (20) @(posedge clk_sys);
        reset <= 0;
        check(peak, `PEAK_RESET);
        rd(`ADDR_OFS, `DEV_ADDR_RESET, 32'h7f);
        rd(`DIV_OFS, `DIV_STD, 32'hffff);
        rd(`STATUS_OFS, 0, 32'h3);
        rd(32'h40, 0, '1);
        ahb(1, `DIV_OFS, 4, 0);
        ep = `PEAK_RESET;
        for (int m = 0; m < 8; m++)
        begin
            slow <= m[0];
            convert(4, m != 2);
            run({m[2], m[1], !m[0], 1'b1});
            rd(`RDATA_OFS, ep, m[1] ? 32'hffff : 32'hff00);
        end
        for (int k = 0; k < 2; k++)
        begin
            wd = k ? `PEAK_CLEAR : 16'($random(seed)) & `PEAK_DATA_MASK;
            ahb(1, `WDATA_OFS, {16'h0, wd}, 0);
            run(4'b0100);
            check(peak, wd);
            ep = wd;
            convert(2, 1);
            run(4'b0101);
            rd(`RDATA_OFS, ep, 32'hffff);
        end
        ahb(1, `ADDR_OFS, 32'h51, 0);
        run(4'b0001);
        rd(`STATUS_OFS, 2, 32'h2);
        finish_test();
    end
endmodule : testbench
